// >>> logic/pp_pkg.sv
// Constants shared by the parallel programming controller and its step timer
package pp_pkg;

   // ------------------------------------------------------------
   // Clock and pin timing
   // ------------------------------------------------------------
   localparam int CLOCK_NS      = 100;
   localparam int PULSE_NS      = 250;       // Least strobe width
   localparam int SETUP_NS      = 67;        // Least setup before a strobe
   localparam int HOLD_NS       = 67;        // Least hold after a strobe
   localparam int OE_DATA_NS    = 250;       // Output enable low to data valid, longest
   localparam int OE_FLOAT_NS   = 250;       // Output enable high to bus released, longest
   localparam int BUSY_LOW_NS   = 1000;      // Write low to busy shown, longest
   localparam int READY_MAX_NS  = 9_000_000; // Longest programming time
   localparam int SYNC_STAGES   = 2;

   localparam logic [7:0] PULSE_CYCLES    = 8'((PULSE_NS + CLOCK_NS - 1) / CLOCK_NS);
   localparam logic [7:0] SETUP_CYCLES    = 8'((SETUP_NS + CLOCK_NS - 1) / CLOCK_NS);
   localparam logic [7:0] HOLD_CYCLES     = 8'((HOLD_NS + CLOCK_NS - 1) / CLOCK_NS);
   localparam logic [7:0] OE_DATA_CYCLES  = 8'((OE_DATA_NS + CLOCK_NS - 1) / CLOCK_NS + SYNC_STAGES);
   localparam logic [7:0] OE_FLOAT_CYCLES = 8'((OE_FLOAT_NS + CLOCK_NS - 1) / CLOCK_NS);
   localparam logic [7:0] BUSY_LOW_CYCLES = 8'(BUSY_LOW_NS / CLOCK_NS + SYNC_STAGES);
   localparam int         READY_CYCLES    = READY_MAX_NS / CLOCK_NS;

   // ------------------------------------------------------------
   // Register map (byte offsets) and fields
   // ------------------------------------------------------------
   localparam logic [3:0] STEP_OFFSET   = 4'h0;
   localparam logic [3:0] STATUS_OFFSET = 4'h4;
   localparam logic [3:0] RDATA_OFFSET  = 4'h8;

   localparam int STEP_DATA_LSB   = 0;
   localparam int STEP_ACTION_LSB = 8;
   localparam int STEP_SELECT_LSB = 10;
   localparam int STEP_OP_LSB     = 12;

   localparam int STATUS_BUSY_BIT    = 0;
   localparam int STATUS_READY_BIT   = 1;
   localparam int STATUS_TIMEOUT_BIT = 2;
   localparam int STATUS_SEEN_BIT    = 3;

   // Step kinds
   localparam logic [1:0] OP_LOAD  = 2'h0;
   localparam logic [1:0] OP_LATCH = 2'h1;
   localparam logic [1:0] OP_WRITE = 2'h2;
   localparam logic [1:0] OP_READ  = 2'h3;

   // Action select codes {hi, lo}
   localparam logic [1:0] ACT_ADDRESS = 2'h0;
   localparam logic [1:0] ACT_DATA    = 2'h1;
   localparam logic [1:0] ACT_COMMAND = 2'h2;
   localparam logic [1:0] ACT_IDLE    = 2'h3;

   // Byte select codes {hi, lo}
   localparam logic [1:0] SEL_LOW  = 2'h0;
   localparam logic [1:0] SEL_HIGH = 2'h1;
   localparam logic [1:0] SEL_EXT  = 2'h2;

   // Command bytes of the device
   localparam logic [7:0] CMD_NOP         = 8'h00;
   localparam logic [7:0] CMD_WRITE_FLASH = 8'h10;
   localparam logic [7:0] CMD_WRITE_EEP   = 8'h11;
   localparam logic [7:0] CMD_WRITE_FUSE  = 8'h40;
   localparam logic [7:0] CMD_WRITE_LOCK  = 8'h20;
   localparam logic [7:0] CMD_READ_FLASH  = 8'h02;
   localparam logic [7:0] CMD_READ_EEP    = 8'h03;
   localparam logic [7:0] CMD_READ_FUSE   = 8'h04;
   localparam logic [7:0] CMD_READ_SIG    = 8'h08;

endpackage : pp_pkg

// >>> logic/step_if.sv
// Handshake between the sequencer and its phase timer
interface step_if;
   logic       start;
   logic [7:0] cycles;
   logic       done;

   modport timer (input start, input cycles, output done);
   modport user  (output start, output cycles, input done);
endinterface : step_if

// >>> logic/step_timer.sv
// Phase timer: done after the loaded number of cycles has run
module step_timer
   import pp_pkg::*;
(
   input wire logic clock,
   input wire logic reset_n,
   step_if.timer    steps
);

   logic [7:0] remain;

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         remain <= 8'h00;
      end else if (steps.start) begin
         remain <= steps.cycles;
      end else if (remain != 8'h00) begin
         remain <= remain - 8'h01;
      end
   end

   // A phase kicked with N lasts N+1 cycles, the kick cycle included
   assign steps.done = !steps.start && (remain <= 8'h01);

endmodule : step_timer

// >>> logic/pp_programmer.sv
// Host controller driving the parallel programming pins of the target device
module pp_programmer
   import pp_pkg::*;
#(
   parameter int READY_TIMEOUT = READY_CYCLES
)
(
   input  wire logic        clock,
   input  wire logic        reset_n,
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   output logic             action_select_hi,
   output logic             action_select_lo,
   output logic             byte_select_hi,
   output logic             byte_select_lo,
   output logic             load_strobe,
   output logic             page_latch_strobe,
   output logic             write_strobe_n,
   output logic             output_enable_n,
   output logic      [7:0]  data_out,
   output logic             data_oe_n,
   input  wire logic [7:0]  data_in,
   input  wire logic        ready_flag
);

   typedef enum {S_IDLE, S_SETUP, S_PULSE, S_HOLD, S_WAIT_LOW, S_WAIT_HIGH} state_t;

   state_t      state;
   logic [1:0]  step_op;
   logic [1:0]  step_action;
   logic [1:0]  step_select;
   logic [7:0]  step_data;
   logic [7:0]  read_byte;
   logic        timed_out;
   logic        busy_seen;
   logic        read_done;
   logic [23:0] wait_count;
   logic        ready_meta;
   logic        ready_sync;
   logic [7:0]  data_meta;
   logic [7:0]  data_sync;
   logic        busy;
   logic        step_hit;
   logic        accept_step;
   logic        wait_expired;

   step_if steps ();

   step_timer phase_timer (
      .clock   (clock),
      .reset_n (reset_n),
      .steps   (steps)
   );

   // ------------------------------------------------------------
   // Pin input synchronisers
   // ------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         ready_meta <= 1'b0;
         ready_sync <= 1'b0;
         data_meta  <= 8'h00;
         data_sync  <= 8'h00;
      end else begin
         ready_meta <= ready_flag;
         ready_sync <= ready_meta;
         data_meta  <= data_in;
         data_sync  <= data_meta;
      end
   end

   // ------------------------------------------------------------
   // Avalon-MM slave
   // ------------------------------------------------------------
   assign busy         = (state != S_IDLE);
   assign step_hit     = avs_write && (avs_address == STEP_OFFSET)
                         && (avs_byteenable[1:0] == 2'h3);
   assign accept_step  = step_hit && !busy;
   // A new step stalls the bus until the previous one has fully ended
   assign avs_waitrequest = (avs_read && !read_done) || (step_hit && busy);

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         read_done    <= 1'b0;
         avs_readdata <= 32'h0000_0000;
      end else begin
         read_done <= avs_read && !read_done;
         if (avs_read && !read_done) begin
            case (avs_address)
               STEP_OFFSET: begin
                  avs_readdata <= {18'h00000, step_op, step_select, step_action, step_data};
               end
               STATUS_OFFSET: begin
                  avs_readdata <= {28'h0000000, busy_seen, timed_out, ready_sync, busy};
               end
               RDATA_OFFSET: begin
                  avs_readdata <= {24'h000000, read_byte};
               end
               default: begin
                  avs_readdata <= 32'h0000_0000;
               end
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // Ready wait watchdog
   // ------------------------------------------------------------
   // Bounds a target that never returns ready; status bit 2 reports it
   assign wait_expired = (wait_count == 24'(READY_TIMEOUT));

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         wait_count <= 24'h000000;
      end else if (state == S_WAIT_HIGH && !wait_expired) begin
         wait_count <= wait_count + 24'h000001;
      end else if (state != S_WAIT_HIGH) begin
         wait_count <= 24'h000000;
      end
   end

   // ------------------------------------------------------------
   // Pin sequencer
   // ------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         state             <= S_IDLE;
         step_op           <= OP_LOAD;
         step_action       <= ACT_IDLE;
         step_select       <= SEL_LOW;
         step_data         <= 8'h00;
         read_byte         <= 8'h00;
         timed_out         <= 1'b0;
         busy_seen         <= 1'b0;
         steps.start       <= 1'b0;
         steps.cycles      <= 8'h00;
         action_select_hi  <= 1'b1;
         action_select_lo  <= 1'b1;
         byte_select_hi    <= 1'b0;
         byte_select_lo    <= 1'b0;
         load_strobe       <= 1'b0;
         page_latch_strobe <= 1'b0;
         write_strobe_n    <= 1'b1;
         output_enable_n   <= 1'b1;
         data_out          <= 8'h00;
         data_oe_n         <= 1'b1;
      end else begin
         steps.start <= 1'b0;
         case (state)
            S_IDLE: begin
               if (accept_step) begin
                  step_op     <= avs_writedata[STEP_OP_LSB +: 2];
                  step_action <= avs_writedata[STEP_ACTION_LSB +: 2];
                  step_select <= avs_writedata[STEP_SELECT_LSB +: 2];
                  step_data   <= avs_writedata[STEP_DATA_LSB +: 8];
                  timed_out   <= 1'b0;
                  busy_seen   <= 1'b0;
                  {action_select_hi, action_select_lo} <= avs_writedata[STEP_ACTION_LSB +: 2];
                  byte_select_hi <= avs_writedata[STEP_SELECT_LSB + 1];
                  byte_select_lo <= avs_writedata[STEP_SELECT_LSB];
                  // Command loads always go with select low at 0
                  if (avs_writedata[STEP_OP_LSB +: 2] == OP_LOAD
                      && avs_writedata[STEP_ACTION_LSB +: 2] == ACT_COMMAND) begin
                     byte_select_lo <= 1'b0;
                  end
                  if (avs_writedata[STEP_OP_LSB +: 2] == OP_LATCH) begin
                     byte_select_lo <= 1'b1;
                  end
                  data_out  <= avs_writedata[STEP_DATA_LSB +: 8];
                  // Only loads drive the bus; reads leave it to the device
                  data_oe_n <= (avs_writedata[STEP_OP_LSB +: 2] != OP_LOAD);
                  steps.start  <= 1'b1;
                  steps.cycles <= SETUP_CYCLES;
                  state        <= S_SETUP;
               end
            end
            S_SETUP: begin
               if (steps.done) begin
                  steps.start  <= 1'b1;
                  steps.cycles <= PULSE_CYCLES;
                  state        <= S_PULSE;
                  case (step_op)
                     OP_LOAD: begin
                        load_strobe <= 1'b1;
                     end
                     OP_LATCH: begin
                        page_latch_strobe <= 1'b1;
                     end
                     OP_WRITE: begin
                        write_strobe_n <= 1'b0;
                     end
                     default: begin
                        output_enable_n <= 1'b0;
                        steps.cycles    <= OE_DATA_CYCLES;
                     end
                  endcase
               end
            end
            S_PULSE: begin
               if (steps.done) begin
                  load_strobe       <= 1'b0;
                  page_latch_strobe <= 1'b0;
                  write_strobe_n    <= 1'b1;
                  output_enable_n   <= 1'b1;
                  steps.start       <= 1'b1;
                  steps.cycles      <= HOLD_CYCLES;
                  state             <= S_HOLD;
                  if (step_op == OP_READ) begin
                     read_byte    <= data_sync;
                     steps.cycles <= OE_FLOAT_CYCLES;
                  end
                  if (step_op == OP_WRITE) begin
                     steps.cycles <= BUSY_LOW_CYCLES;
                     state        <= S_WAIT_LOW;
                  end
               end
            end
            S_WAIT_LOW: begin
               // A missed busy phase is tolerated: very short writes may hide it
               if (!ready_sync || steps.done) begin
                  busy_seen <= !ready_sync;
                  state     <= S_WAIT_HIGH;
               end
            end
            S_WAIT_HIGH: begin
               if (ready_sync || wait_expired) begin
                  timed_out      <= !ready_sync;
                  byte_select_hi <= 1'b0;
                  byte_select_lo <= 1'b0;
                  steps.start    <= 1'b1;
                  steps.cycles   <= HOLD_CYCLES;
                  state          <= S_HOLD;
               end
            end
            S_HOLD: begin
               if (steps.done) begin
                  data_oe_n <= 1'b1;
                  state     <= S_IDLE;
               end
            end
            default: begin
               state <= S_IDLE;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!reset_n);

   cmd_select_low_a: assert property (
      (load_strobe && {action_select_hi, action_select_lo} == ACT_COMMAND) |-> !byte_select_lo)
      else $error("command load with byte select low set");

   load_hold_a: assert property (
      $fell(load_strobe) |-> ($stable(data_out) && $stable(byte_select_hi)
         && $stable(byte_select_lo) && !data_oe_n) [*2])
      else $error("load pins changed within hold");

   load_width_a: assert property (
      $rose(load_strobe) |-> load_strobe [*4] ##1 !load_strobe)
      else $error("load strobe width wrong");

   load_setup_a: assert property (
      $rose(load_strobe) |-> $past(!data_oe_n, 2) && $stable(data_out))
      else $error("bus not set up before load strobe");

   latch_select_a: assert property (
      $rose(page_latch_strobe) |-> byte_select_lo && $past(byte_select_lo)
         ##4 !page_latch_strobe && byte_select_lo)
      else $error("page latch without select low high");

   write_width_a: assert property (
      $fell(write_strobe_n) |-> !write_strobe_n [*4] ##1 write_strobe_n)
      else $error("write strobe width wrong");

   ready_wait_a: assert property (
      (state == S_WAIT_HIGH && !ready_sync && !wait_expired) |=> state == S_WAIT_HIGH)
      else $error("left ready wait while device busy");

   wait_bound_a: assert property (
      (state == S_WAIT_HIGH && wait_expired && !ready_sync) |=> (state == S_HOLD && timed_out))
      else $error("ready wait not ended by timeout");

   select_return_a: assert property (
      ($past(state) == S_WAIT_HIGH && state == S_HOLD)
         |-> {byte_select_hi, byte_select_lo} == SEL_LOW)
      else $error("byte selects not returned to 00");

   bus_turn_a: assert property (
      !output_enable_n |-> data_oe_n)
      else $error("bus driven while output enable low");

   read_width_a: assert property (
      $fell(output_enable_n) |-> !output_enable_n [*6] ##1 output_enable_n)
      else $error("output enable low time wrong");

   cover property ($rose(load_strobe) && data_out == CMD_WRITE_FLASH
      && {action_select_hi, action_select_lo} == ACT_COMMAND);
   cover property ($rose(load_strobe) && data_out == CMD_NOP
      && {action_select_hi, action_select_lo} == ACT_COMMAND);
   cover property ($rose(page_latch_strobe));
   cover property (state == S_WAIT_HIGH ##1 state == S_HOLD && busy_seen);
   cover property ($rose(output_enable_n));

endmodule : pp_programmer

// >>> testbench/target_model.sv
// Behavioural model of the target device on the parallel programming pins
module target_model #(
   parameter int         BUSY_CYCLES = 30,
   parameter int         DATA_DELAY  = 2,
   parameter logic [7:0] SIG_BYTE0   = 8'h3c,   // Identity values are arbitrary
   parameter logic [7:0] SIG_BYTE1   = 8'h5d,
   parameter logic [7:0] SIG_BYTE2   = 8'h1e,
   parameter logic [7:0] CAL_BYTE    = 8'ha7
)
(
   input  wire logic       clock,
   input  wire logic       hang,
   input  wire logic       action_select_hi,
   input  wire logic       action_select_lo,
   input  wire logic       byte_select_hi,
   input  wire logic       byte_select_lo,
   input  wire logic       load_strobe,
   input  wire logic       page_latch_strobe,
   input  wire logic       write_strobe_n,
   input  wire logic       output_enable_n,
   input  wire logic [7:0] bus,
   output logic      [7:0] dev_bus,
   output logic            ready_flag
);
   timeunit 1ns;
   timeprecision 1ns;

   logic [7:0]  command = 8'h00;
   logic [23:0] address = 24'h0;
   logic [7:0]  data_lo = 8'hff, data_hi = 8'hff;
   logic [7:0]  fuse_lo = 8'hff, fuse_hi = 8'hff, fuse_ext = 8'hff, lock = 8'hff;
   logic [2:0]  prev    = 3'b001;
   int          busy    = 0;
   int          oe_count = 0;
   logic [15:0] page_buf [int];
   logic [15:0] flash    [int];
   logic [7:0]  eep_buf  [int];
   logic [7:0]  eep      [int];

   initial dev_bus = 8'h00;
   assign ready_flag = (busy == 0);

   function automatic logic [7:0] read_value();
      logic [15:0] word;
      word = flash.exists(int'(address[15:0])) ? flash[int'(address[15:0])] : 16'hffff;
      case (command)
         8'h02: return byte_select_lo ? word[15:8] : word[7:0];
         8'h03: return eep.exists(int'(address[10:0])) ?
                       eep[int'(address[10:0])] : 8'hff;
         8'h04: case ({byte_select_hi, byte_select_lo})
            2'h0: return fuse_lo;
            2'h3: return fuse_hi;
            2'h2: return fuse_ext;
            default: return lock;
         endcase
         8'h08: if (byte_select_lo) return CAL_BYTE;
            else return (address[1:0] == 2'h0) ? SIG_BYTE0 :
                        (address[1:0] == 2'h1) ? SIG_BYTE1 : SIG_BYTE2;
         default: return 8'hff;
      endcase
   endfunction : read_value

   always @(posedge clock) begin
      prev <= {load_strobe, page_latch_strobe, write_strobe_n};
      if (load_strobe && !prev[2]) begin
         case ({action_select_hi, action_select_lo})
            2'h2: begin
               command <= bus;
               if (bus == 8'h00) page_buf.delete();
            end
            2'h0: case ({byte_select_hi, byte_select_lo})
               2'h0: address[7:0] <= bus;
               2'h1: address[15:8] <= bus;
               2'h2: address[23:16] <= bus;
               default: ;
            endcase
            2'h1: if (byte_select_lo) data_hi <= bus; else data_lo <= bus;
            default: ;
         endcase
      end
      if (page_latch_strobe && !prev[1] && byte_select_lo) begin
         page_buf[int'(address[6:0])] = {data_hi, data_lo};
         eep_buf[int'(address[2:0])] = data_lo;
      end
      if (!write_strobe_n && prev[0] && command inside {8'h10, 8'h11, 8'h40, 8'h20}) begin
         busy <= BUSY_CYCLES;
         case (command)
            8'h10: foreach (page_buf[i])
                      flash[int'({address[15:7], 7'(i)})] = page_buf[i];
            8'h11: foreach (eep_buf[i]) eep[int'({address[10:3], 3'(i)})] = eep_buf[i];
            8'h40: case ({byte_select_hi, byte_select_lo})
               2'h0: fuse_lo <= data_lo;
               2'h1: fuse_hi <= data_lo;
               2'h2: fuse_ext <= data_lo;
               default: ;
            endcase
            default: lock <= lock
                        & ((lock[1:0] == 2'h0) ? (data_lo | 8'hfc) : data_lo);
         endcase
         page_buf.delete();
         eep_buf.delete();
      end else if (busy != 0 && !hang) busy <= busy - 1;
      oe_count <= output_enable_n ? 0 : oe_count + 1;
      // Released bus toggles so a stale byte can never be captured
      dev_bus <= (!output_enable_n && oe_count >= DATA_DELAY) ? read_value() : ~dev_bus;
   end
endmodule : target_model

// >>> testbench/parallel_memory_programming_port_tb_top.sv
// Self-checking bench for the parallel programming controller
`define CHECK(what, exp, got) begin \
   samples_checked++; \
   if ((got) !== (exp)) begin \
      miscompares++; \
      $display("wrong value %s expected %h seen %h", what, exp, got); \
   end \
end
module parallel_memory_programming_port_tb_top
   import pp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   localparam int         CYCLE_LIMIT = 20000;
   localparam logic [7:0] SIG0 = 8'h3c, SIG1 = 8'h5d, SIG2 = 8'h1e, CAL = 8'ha7;
   logic        clock = 1'b0, reset_n, avs_read, avs_write, hang;
   logic [3:0]  avs_address, avs_byteenable;
   logic [31:0] avs_writedata, avs_readdata, v;
   logic        avs_waitrequest, ahi, alo, bhi, blo, lds, pls, wr_n, oe_n, data_oe_n, ready_flag;
   logic [7:0]  data_out, dev_bus;
   wire  [7:0]  data_in = data_oe_n ? dev_bus : data_out;
   int          miscompares = 0, samples_checked = 0, cycle_count = 0;
   logic [7:0]  fuse_val [3] = '{8'h5a, 8'hc3, 8'hfe};
   logic [1:0]  fuse_wsel [3] = '{SEL_LOW, SEL_HIGH, SEL_EXT};
   logic [1:0]  fuse_rsel [3] = '{2'h0, 2'h3, 2'h2};
   logic [7:0]  sig [3] = '{SIG0, SIG1, SIG2};

   pp_programmer #(.READY_TIMEOUT(200)) pp_programmer_i (.clock(clock), .reset_n(reset_n),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .action_select_hi(ahi), .action_select_lo(alo), .byte_select_hi(bhi),
      .byte_select_lo(blo), .load_strobe(lds), .page_latch_strobe(pls),
      .write_strobe_n(wr_n), .output_enable_n(oe_n), .data_out(data_out),
      .data_oe_n(data_oe_n), .data_in(data_in), .ready_flag(ready_flag));
   target_model target_model_i (.clock(clock), .hang(hang), .action_select_hi(ahi),
      .action_select_lo(alo), .byte_select_hi(bhi), .byte_select_lo(blo),
      .load_strobe(lds), .page_latch_strobe(pls), .write_strobe_n(wr_n),
      .output_enable_n(oe_n), .bus(data_in), .dev_bus(dev_bus), .ready_flag(ready_flag));

   initial begin
      forever #50 clock = ~clock;
   end

   task automatic complete_run();
      $display("checks %0d wrong %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : complete_run

   always @(posedge clock) begin
      cycle_count <= cycle_count + 1;
      if (cycle_count == CYCLE_LIMIT) begin
         miscompares++;
         complete_run();
      end
   end

   // ------------------------------------------------------------
   // Bus and step tasks
   // ------------------------------------------------------------
   task automatic av_write(input logic [3:0] a, input logic [31:0] d);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= 1'b1;
      do @(posedge clock); while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
      @(posedge clock);
   endtask : av_write

   task automatic av_read(input logic [3:0] a, output logic [31:0] d);
      avs_address <= a;
      avs_read <= 1'b1;
      do @(posedge clock); while (avs_waitrequest !== 1'b0);
      d = avs_readdata;
      avs_read <= 1'b0;
      @(posedge clock);
   endtask : av_read

   task automatic run(input logic [1:0] op, act, sel, input logic [7:0] d);
      av_write(STEP_OFFSET, 32'({op, sel, act, d}));
      do av_read(STATUS_OFFSET, v); while (v[STATUS_BUSY_BIT] !== 1'b0);
   endtask : run

   task automatic cmd(input logic [7:0] d); run(OP_LOAD, ACT_COMMAND, SEL_LOW, d); endtask : cmd
   task automatic adr(input logic [1:0] s, input logic [7:0] d);
      run(OP_LOAD, ACT_ADDRESS, s, d);
   endtask : adr
   task automatic dat(input logic [1:0] s, input logic [7:0] d);
      run(OP_LOAD, ACT_DATA, s, d);
   endtask : dat
   task automatic latch(); run(OP_LATCH, ACT_IDLE, SEL_HIGH, 8'h00); endtask : latch

   task automatic prog(input logic [1:0] s, input logic [31:0] exp);
      run(OP_WRITE, ACT_IDLE, s, 8'h00);
      av_read(STATUS_OFFSET, v);
      `CHECK("status", exp, v)
      `CHECK("ready pin", exp[STATUS_READY_BIT], ready_flag)
      `CHECK("selects after write", 2'h0, {bhi, blo})
   endtask : prog

   task automatic rd_check(input logic [1:0] s, input logic [7:0] exp);
      run(OP_READ, ACT_IDLE, s, 8'h00);
      av_read(RDATA_OFFSET, v);
      `CHECK("read byte", exp, v[7:0])
   endtask : rd_check

   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      reset_n = 1'b0; avs_read = 1'b0; avs_write = 1'b0; hang = 1'b0;
      avs_address = 4'h0; avs_writedata = 32'h0; avs_byteenable = 4'hf;
      repeat (3) @(posedge clock);
      reset_n <= 1'b1;
      @(posedge clock);
      `CHECK("idle pins", 9'b110000111, {ahi, alo, bhi, blo, lds, pls, wr_n, oe_n, data_oe_n})
      cmd(CMD_WRITE_FLASH);
      adr(SEL_LOW, 8'h85);
      dat(SEL_LOW, 8'h34);
      dat(SEL_HIGH, 8'h12);
      latch();
      adr(SEL_HIGH, 8'h01);
      adr(SEL_EXT, 8'h00);
      prog(SEL_LOW, 32'ha);
      cmd(CMD_NOP);
      prog(SEL_LOW, 32'h2);
      cmd(CMD_READ_FLASH);
      adr(SEL_EXT, 8'h00);
      adr(SEL_HIGH, 8'h01);
      adr(SEL_LOW, 8'h85);
      rd_check(SEL_LOW, 8'h34);
      rd_check(SEL_HIGH, 8'h12);
      $display("test flash done");
      cmd(CMD_WRITE_EEP);
      adr(SEL_HIGH, 8'h02);
      adr(SEL_LOW, 8'h13);
      dat(SEL_LOW, 8'ha5);
      latch();
      prog(SEL_LOW, 32'ha);
      cmd(CMD_READ_EEP);
      adr(SEL_HIGH, 8'h02);
      adr(SEL_LOW, 8'h13);
      rd_check(SEL_LOW, 8'ha5);
      $display("test eeprom done");
      for (int i = 0; i < 3; i++) begin
         cmd(CMD_WRITE_FUSE);
         dat(SEL_LOW, fuse_val[i]);
         prog(fuse_wsel[i], 32'ha);
      end
      cmd(CMD_READ_FUSE);
      for (int i = 0; i < 3; i++) rd_check(fuse_rsel[i], fuse_val[i]);
      $display("test fuse done");
      cmd(CMD_WRITE_LOCK);
      dat(SEL_LOW, 8'hfc);
      prog(SEL_LOW, 32'ha);
      dat(SEL_LOW, 8'hc3);
      prog(SEL_LOW, 32'ha);
      dat(SEL_LOW, 8'hff);
      prog(SEL_LOW, 32'ha);
      cmd(CMD_READ_FUSE);
      rd_check(SEL_HIGH, 8'hfc);
      $display("test lock done");
      cmd(CMD_READ_SIG);
      for (int i = 0; i < 3; i++) begin
         adr(SEL_LOW, 8'(i));
         rd_check(SEL_LOW, sig[i]);
      end
      adr(SEL_LOW, 8'h00);
      rd_check(SEL_HIGH, CAL);
      run(OP_LOAD, ACT_IDLE, SEL_LOW, 8'h02);
      rd_check(SEL_LOW, SIG0);
      $display("test signature done");
      hang <= 1'b1;
      cmd(CMD_WRITE_FUSE);
      dat(SEL_LOW, 8'h5a);
      prog(SEL_LOW, 32'hc);
      hang <= 1'b0;
      $display("test timeout done");
      av_read(STEP_OFFSET, v);
      `CHECK("step readback", 32'h2300, v)
      avs_byteenable <= 4'h1;
      av_write(STEP_OFFSET, 32'h0155);
      avs_byteenable <= 4'hf;
      av_read(STEP_OFFSET, v);
      `CHECK("partial write", 32'h2300, v)
      av_read(4'hc, v);
      `CHECK("unmapped read", 32'h0, v)
      $display("test registers done");
      complete_run();
   end
endmodule : parallel_memory_programming_port_tb_top
